/* aeg_pkg.sv */
// Package: constants and carrier types for the event gate and range reject block
package aeg_pkg;
  localparam int unsigned AEG_ADDR_W = 13;
  localparam int unsigned AEG_SEL_W = 4;
  localparam int unsigned AEG_CLK_MHZ = 40;
  localparam int unsigned AEG_VETO_HOLD_NS = 400;
  localparam int unsigned AEG_VETO_HOLD_CYC = (AEG_VETO_HOLD_NS * AEG_CLK_MHZ + 999) / 1000;
  localparam int unsigned AEG_CNT_W = 5;
  localparam logic [AEG_SEL_W-1:0] AEG_LIMIT_SEL_MIN = 4'h5;
  localparam logic [AEG_SEL_W-1:0] AEG_LIMIT_SEL_MAX = 4'hd;
  localparam logic [AEG_SEL_W-1:0] AEG_SHIFT_SEL_OFF = 4'hf;

  typedef enum logic [4:0] {
    AEG_IDLE = 5'h01,
    AEG_SAMPLE = 5'h02,
    AEG_CONVERT = 5'h04,
    AEG_STORE = 5'h08,
    AEG_DISCARD = 5'h10
  } aeg_state_t;

  typedef struct packed {
    logic [AEG_SEL_W-1:0] limit_sel;
    logic [AEG_SEL_W-1:0] shift_sel;
    logic gate_request_mode;
  } aeg_cfg_t;

  typedef struct packed {
    logic valid;
    logic [AEG_ADDR_W-1:0] addr;
  } aeg_result_t;
endpackage

/* aeg_range_check.sv */
// Module: address shift, underflow and overflow test on a finished conversion
`timescale 1ns/1ps
`default_nettype none
module aeg_range_check
  import aeg_pkg::*;
(
  input wire logic [AEG_ADDR_W-1:0] scaler,
  input wire logic [AEG_SEL_W-1:0] shift_sel,
  input wire logic [AEG_SEL_W-1:0] limit_sel,
  output logic [AEG_ADDR_W-1:0] addr,
  output logic in_range
);
  logic [AEG_ADDR_W-1:0] shift_val;
  logic [AEG_ADDR_W-1:0] limit_val;
  logic [AEG_ADDR_W:0] diff;
  logic [AEG_SEL_W-1:0] lim_c;

  always_comb begin
    // Powers of two only; out-of-range shift codes give no shift, out-of-range limit codes clamp
    shift_val = (shift_sel < AEG_SEL_W'(AEG_ADDR_W)) ? (AEG_ADDR_W'(1) << shift_sel) : '0;
    lim_c = (limit_sel < AEG_LIMIT_SEL_MIN) ? AEG_LIMIT_SEL_MIN :
            (limit_sel > AEG_LIMIT_SEL_MAX) ? AEG_LIMIT_SEL_MAX : limit_sel;
    limit_val = AEG_ADDR_W'((AEG_ADDR_W+1)'(1) << lim_c) - AEG_ADDR_W'(1);
    diff = {1'b0, scaler} - {1'b0, shift_val};
    addr = diff[AEG_ADDR_W-1:0];
    // Borrow means underflow; above top channel means overflow
    in_range = !diff[AEG_ADDR_W] && (addr <= limit_val);
  end
endmodule // aeg_range_check
`default_nettype wire

/* aeg_event_gate.sv */
// Module: converter event gate, veto window, range reject and store handshake
// Operation
// - Address above selected channel limit suppresses store and resets internally.
// - Subtract selected address shift before the overflow test.
// - Shifted address below zero is rejected like an overflow.
// - Channel limits include 32 and 64 channel groups.
// - In gate-request mode the linear gate stays closed without a request.
// - An asserted gate request opens the linear gate.
// - Peak detect closes the gate even while request remains.
// - Busy holds the gate closed; further requests have no effect.
// - Request works again only after reject or memory clear.
// - Gated events still pass thresholds, shift and limit checks.
// - Outside gate-request mode, veto at peak detect held about 400 ns discards the event.
// - Veto outside that window has no effect.
// - Vetoed event dead time equals time above low threshold.
// - Veto alone is never counted as dead time.
// - Address shift acts after conversion; conversion time independent of it.
// - Shift and limit settings are powers of two only.
`timescale 1ns/1ps
`default_nettype none
module aeg_event_gate
  import aeg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire aeg_cfg_t cfg,
  input wire logic gate_request,
  input wire logic veto,
  input wire logic low_threshold_detector,
  input wire logic high_threshold_detector,
  input wire logic peak_detect,
  input wire logic conv_done,
  input wire logic [AEG_ADDR_W-1:0] scaler,
  input wire logic mem_clear,
  output logic linear_gate_open,
  output logic busy,
  output logic dead_time,
  output logic converter_reset,
  output logic store,
  output logic [AEG_ADDR_W-1:0] store_addr
);
  ////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage read only by second
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {gate_request, veto, low_threshold_detector, high_threshold_detector,
               peak_detect, conv_done, mem_clear};
      s2_q <= s1_q;
    end
  end
  logic req_s, veto_s, lld_s, uld_s, pk_s, done_s, clr_s;
  assign {req_s, veto_s, lld_s, uld_s, pk_s, done_s, clr_s} = s2_q;

  logic pk_prev_q;
  logic done_prev_q;
  logic clr_prev_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pk_prev_q <= 1'b0;
      done_prev_q <= 1'b0;
      clr_prev_q <= 1'b0;
    end else begin
      pk_prev_q <= pk_s;
      done_prev_q <= done_s;
      clr_prev_q <= clr_s;
    end
  end
  logic pk_rise, done_rise, clr_rise;
  assign pk_rise = pk_s && !pk_prev_q;
  assign done_rise = done_s && !done_prev_q;
  assign clr_rise = clr_s && !clr_prev_q;

  ////////////////////////////////////////////////////////////////
  // Range test on scaler result
  logic [AEG_ADDR_W-1:0] chk_addr;
  logic chk_ok;
  aeg_range_check u_range (
    .scaler(scaler),
    .shift_sel(cfg.shift_sel),
    .limit_sel(cfg.limit_sel),
    .addr(chk_addr),
    .in_range(chk_ok)
  );

  ////////////////////////////////////////////////////////////////
  // Event state machine
  aeg_state_t state_q;
  logic [AEG_CNT_W-1:0] veto_cnt_q;
  logic reject_d;
  logic accept_d;

  // Window counts only while veto holds; early veto alone counts nothing
  assign reject_d = (state_q == AEG_SAMPLE) && !veto_s;
  // Veto must still stand on the last sample, else the event converts
  assign accept_d = (state_q == AEG_SAMPLE) && veto_s && (veto_cnt_q == AEG_CNT_W'(AEG_VETO_HOLD_CYC));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= AEG_IDLE;
      veto_cnt_q <= '0;
    end else begin
      case (state_q)
        AEG_IDLE: begin
          veto_cnt_q <= '0;
          // High threshold inhibits conversion
          if (pk_rise && lld_s && !uld_s &&
              (!cfg.gate_request_mode || linear_gate_open)) begin
            if (!cfg.gate_request_mode && veto_s) begin
              state_q <= AEG_SAMPLE;
              veto_cnt_q <= AEG_CNT_W'(1);
            end else begin
              state_q <= AEG_CONVERT;
            end
          end
        end
        AEG_SAMPLE: begin
          // Veto dropped early: event proceeds as normal
          if (reject_d) begin
            state_q <= AEG_CONVERT;
          end else if (veto_cnt_q == AEG_CNT_W'(AEG_VETO_HOLD_CYC)) begin
            state_q <= AEG_DISCARD;
          end else begin
            veto_cnt_q <= veto_cnt_q + AEG_CNT_W'(1);
          end
        end
        AEG_CONVERT: begin
          // Shift applied only on finished result
          if (done_rise) begin
            state_q <= chk_ok ? AEG_STORE : AEG_DISCARD;
          end
        end
        AEG_STORE: begin
          if (clr_rise) begin
            state_q <= AEG_IDLE;
          end
        end
        AEG_DISCARD: begin
          // Vetoed event is released once input falls below low threshold
          if (!lld_s) begin
            state_q <= AEG_IDLE;
          end
        end
        default: state_q <= AEG_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs, all registered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      linear_gate_open <= 1'b0;
    end else if (state_q != AEG_IDLE || pk_rise) begin
      linear_gate_open <= 1'b0;
    end else if (cfg.gate_request_mode) begin
      linear_gate_open <= req_s;
    end else begin
      linear_gate_open <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      dead_time <= 1'b0;
    end else begin
      busy <= (state_q != AEG_IDLE);
      // Veto level itself never feeds dead time
      dead_time <= (state_q != AEG_IDLE) || (lld_s && linear_gate_open);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      converter_reset <= 1'b0;
    end else begin
      // One pulse when an event is thrown away internally
      converter_reset <= (state_q == AEG_CONVERT && done_rise && !chk_ok) || accept_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      store <= 1'b0;
      store_addr <= '0;
    end else if (state_q == AEG_CONVERT && done_rise && chk_ok) begin
      store <= 1'b1;
      store_addr <= chk_addr;
    end else if (state_q != AEG_STORE || clr_rise) begin
      store <= 1'b0;
    end
  end
endmodule // aeg_event_gate
`default_nettype wire

/* aeg_event_gate_monitor.sv */
// Checker for the event gate and range reject block
`timescale 1ns/1ps
`default_nettype none
module aeg_event_gate_monitor
  import aeg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire aeg_cfg_t cfg,
  input wire logic gate_request,
  input wire logic veto,
  input wire logic low_threshold_detector,
  input wire logic high_threshold_detector,
  input wire logic peak_detect,
  input wire logic conv_done,
  input wire logic [AEG_ADDR_W-1:0] scaler,
  input wire logic mem_clear,
  input wire logic linear_gate_open,
  input wire logic busy,
  input wire logic dead_time,
  input wire logic converter_reset,
  input wire logic store,
  input wire logic [AEG_ADDR_W-1:0] store_addr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic [AEG_SEL_W-1:0] lc;
  // Limit code clamps, as the selector does
  always_comb lc = cfg.limit_sel < AEG_LIMIT_SEL_MIN ? AEG_LIMIT_SEL_MIN :
                   (cfg.limit_sel > AEG_LIMIT_SEL_MAX ? AEG_LIMIT_SEL_MAX : cfg.limit_sel);
  ////////////////////////////////////////////////////////////////
  busy_gate_a: assert property (busy |-> !linear_gate_open) else $error("gate open while busy");
  gate_shut_a: assert property ((cfg.gate_request_mode && !gate_request) [*5] |-> !linear_gate_open)
    else $error("gate open without request");
  // Peak closes the gate a cycle before busy rises, so peaks are kept out
  req_open_a: assert property ((cfg.gate_request_mode && gate_request && !busy && !peak_detect) [*5] |->
    linear_gate_open || busy) else $error("request did not open gate");
  store_hold_a: assert property ($fell(store) |-> $past(mem_clear)) else $error("store dropped early");
  addr_hold_a: assert property (store && $past(store) |-> $stable(store_addr)) else $error("addr moved");
  dead_busy_a: assert property (busy |-> dead_time) else $error("busy not dead");
  veto_dead_a: assert property ((!busy && !low_threshold_detector) [*5] |-> !dead_time)
    else $error("idle counted dead");
  limit_top_a: assert property ($rose(store) |-> (store_addr >> lc) == '0) else $error("addr over limit");
  reset_pulse_a: assert property (converter_reset |=> !converter_reset) else $error("reset pulse long");
  cover property ($rose(store));
  cover property (converter_reset);
  cover property (busy && cfg.gate_request_mode);
endmodule // aeg_event_gate_monitor
`default_nettype wire

/* aeg_mem_model.sv */
// Memory unit model answering store with clear
`timescale 1ns/1ps
`default_nettype none
module aeg_mem_model (
  input wire logic clock,
  input wire logic store,
  input wire logic [3:0] lag,
  output logic mem_clear
);
  logic [3:0] cnt_q = 4'h0;
  // Clear after a variable lag, held until store drops
  always @(posedge clock) begin
    // Unknown store before reset must not raise clear
    if (store !== 1'b1) begin
      mem_clear <= 1'b0;
      cnt_q <= 4'h0;
    end else if (cnt_q == lag) mem_clear <= 1'b1;
    else cnt_q <= cnt_q + 4'h1;
  end
endmodule // aeg_mem_model
`default_nettype wire

/* aeg_event_gate_tb_top.sv */
// Testbench for the event gate and range reject block
`timescale 1ns/1ps
`default_nettype none
module aeg_event_gate_tb_top
  import aeg_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, gate_request = 1'b0, veto = 1'b0, peak_detect = 1'b0, conv_done = 1'b0;
  logic low_threshold_detector = 1'b0, mem_clear, linear_gate_open, busy, dead_time, converter_reset, store, st_q;
  logic [AEG_ADDR_W-1:0] scaler = '0, store_addr;
  logic [3:0] lag = 4'h0;
  aeg_cfg_t cfg = '0;
  aeg_result_t exp_q[$];
  int bad_count = 0, check_count = 0, cyc = 0;
  always #12.5 clock = ~clock;
  aeg_event_gate DUT (.clock(clock), .rst_n(rst_n), .cfg(cfg), .gate_request(gate_request), .veto(veto),
    .low_threshold_detector(low_threshold_detector), .high_threshold_detector(1'b0), .peak_detect(peak_detect),
    .conv_done(conv_done), .scaler(scaler), .mem_clear(mem_clear), .linear_gate_open(linear_gate_open),
    .busy(busy), .dead_time(dead_time), .converter_reset(converter_reset), .store(store), .store_addr(store_addr));
  aeg_mem_model MEM (.clock(clock), .store(store), .lag(lag), .mem_clear(mem_clear));
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (exp_q.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic lvl(logic got, logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk(aeg_result_t got);
    aeg_result_t e;
    check_count++;
    e = exp_q.size() != 0 ? exp_q.pop_front() : '1;
    if (got !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, e);
    end
  endtask
  // Sampled mid-cycle so registered outputs have settled
  always @(negedge clock) begin
    st_q <= store;
    if (store === 1'b1 && st_q !== 1'b1) chk({1'b1, store_addr});
    if (converter_reset !== 1'b0) chk('0);
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic ev(logic gm, logic [3:0] sh, lm, logic [12:0] v, logic [1:0] vt, logic req);
    int s, l, r;
    logic acc;
    aeg_result_t e;
    acc = !gm || req;
    s = sh >= AEG_ADDR_W ? 0 : 1 << sh;
    l = lm < AEG_LIMIT_SEL_MIN ? int'(AEG_LIMIT_SEL_MIN) : (lm > AEG_LIMIT_SEL_MAX ? int'(AEG_LIMIT_SEL_MAX) : int'(lm));
    r = int'(v) - s;
    e = (r < 0 || r >= (1 << l) || vt == 2'h1) ? '0 : {1'b1, AEG_ADDR_W'(r)};
    if (acc) exp_q.push_back(e);
    cfg = {lm, sh, gm};
    low_threshold_detector = 1'b1;
    gate_request = req;
    veto = vt != 2'h0;
    repeat (4) @(negedge clock);
    if (vt == 2'h2) veto = 1'b0;
    // Request stands 20 cycles before the peak
    repeat (16) @(negedge clock);
    lvl(linear_gate_open, acc);
    lvl(dead_time, acc);
    peak_detect = 1'b1;
    repeat (4) @(negedge clock);
    lvl(busy, acc);
    lvl(linear_gate_open, 1'b0);
    peak_detect = 1'b0;
    repeat (16) @(negedge clock);
    gate_request = 1'b0;
    repeat (2) @(negedge clock);
    gate_request = acc & gm;
    peak_detect = acc;
    // Long veto, about two microseconds in all
    if (vt == 2'h1) repeat (40) @(negedge clock);
    veto = 1'b0;
    scaler = v;
    conv_done = acc && vt != 2'h1;
    repeat (4) @(negedge clock);
    {conv_done, peak_detect, gate_request, low_threshold_detector} = '0;
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clock);
    repeat (6) @(negedge clock);
  endtask
  initial begin
    void'($urandom(14641));
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    ev(0, 4'hf, 4'h5, 13'h1f, 0, 1);
    ev(0, 4'hf, 4'h5, 13'h20, 0, 1);
    ev(0, 4'h6, 4'h6, 13'h7f, 0, 1);
    ev(0, 4'h6, 4'h6, 13'h3f, 0, 1);
    ev(1, 4'hf, 4'hd, 13'h123, 0, 0);
    ev(1, 4'h3, 4'h9, 13'h123, 0, 1);
    ev(0, 4'hf, 4'hd, 13'h55, 1, 1);
    ev(0, 4'hf, 4'hd, 13'h55, 2, 1);
    for (int i = 0; i < 40; i++) begin
      lag = 4'($urandom);
      ev(1'($urandom), 4'($urandom), 4'($urandom), 13'($urandom), 0, 1);
    end
    end_sim();
  end
endmodule // aeg_event_gate_tb_top
bind aeg_event_gate aeg_event_gate_monitor mon (.clock(clock), .rst_n(rst_n), .cfg(cfg),
  .gate_request(gate_request), .veto(veto), .low_threshold_detector(low_threshold_detector),
  .high_threshold_detector(high_threshold_detector), .peak_detect(peak_detect), .conv_done(conv_done),
  .scaler(scaler), .mem_clear(mem_clear), .linear_gate_open(linear_gate_open), .busy(busy),
  .dead_time(dead_time), .converter_reset(converter_reset), .store(store), .store_addr(store_addr));
`default_nettype wire
